/* File: core/fsps_page_buffer.sv */
// Temporary page buffer of flip-flops with a per-word loaded marker
module fsps_page_buffer
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire fsps_pkg::fsps_buf_req_t req_i,
   input wire logic [fsps_pkg::WORD_W-1:0] raddr_i,
   output logic [15:0] rdata_o,
   output logic [fsps_pkg::PAGE_WORDS-1:0] loaded_o
);

   typedef struct packed
   {
      logic [fsps_pkg::PAGE_WORDS-1:0][15:0] mem;
      logic [fsps_pkg::PAGE_WORDS-1:0] loaded;
   } fsps_buf_state_t;

   fsps_buf_state_t st_q;
   fsps_buf_state_t st_d;

   always_comb
   begin
      st_d = st_q;
      if (req_i.clear)
      begin
         st_d.mem = '1;
         st_d.loaded = '0;
      end
      else if (req_i.we)
      begin
         st_d.mem[req_i.addr] = req_i.wdata;
         st_d.loaded[req_i.addr] = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q.mem <= '1;
         st_q.loaded <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign rdata_o = st_q.mem[raddr_i];
   assign loaded_o = st_q.loaded;

endmodule

/* File: core/fsps_pkg.sv */
// Package of constants and carrier types for the flash self-programming sequencer
package fsps_pkg;

   // ==========================================
   // Control register field positions
   localparam int unsigned CTL_ENABLE_BIT = 0;
   localparam int unsigned CTL_ERASE_BIT = 1;
   localparam int unsigned CTL_WRITE_BIT = 2;
   localparam int unsigned CTL_LOCKSET_BIT = 3;
   localparam int unsigned CTL_REENABLE_BIT = 4;
   localparam int unsigned CTL_RWWBUSY_BIT = 6;
   localparam int unsigned CTL_IRQEN_BIT = 7;

   // ==========================================
   // Commands, low seven bits of the control write
   localparam logic [6:0] CMD_LOAD = 7'h01;
   localparam logic [6:0] CMD_ERASE = 7'h03;
   localparam logic [6:0] CMD_WRITE = 7'h05;
   localparam logic [6:0] CMD_LOCKPROG = 7'h09;
   localparam logic [6:0] CMD_REENABLE = 7'h11;
   localparam logic [6:0] CMD_READFUSE = 7'h09;

   // ==========================================
   // Geometry: 32-word pages, 128 pages, last 32 pages are the no-read-while-write section
   localparam int unsigned WORD_W = 5;
   localparam int unsigned PAGE_W = 7;
   localparam int unsigned PAGE_WORDS = 32;
   localparam logic [6:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h60;
   localparam int unsigned PTR_PAGE_LSB = 6;
   localparam int unsigned PTR_WORD_LSB = 1;

   // ==========================================
   // Pointer values for fuse and lock reads
   localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
   localparam logic [15:0] PTR_LOCK = 16'h0001;
   localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

   // ==========================================
   // Timing windows in cycles after the control write
   localparam logic [2:0] STORE_WINDOW = 3'h4;
   localparam logic [2:0] LOAD_WINDOW = 3'h3;

   // Lock byte reset value and boot lock bit range of the lock write data
   localparam logic [7:0] LOCK_RESET = 8'hff;
   localparam int unsigned LOCK_BOOT_LSB = 2;
   localparam int unsigned LOCK_BOOT_MSB = 5;

   typedef enum logic [2:0]
   {
      FSPS_IDLE = 3'b000,
      FSPS_ARMED = 3'b001,
      FSPS_BUSY = 3'b010,
      FSPS_LOCKBUSY = 3'b011
   } fsps_state_t;

   typedef enum logic [1:0]
   {
      FSPS_OP_ERASE = 2'b00,
      FSPS_OP_WRITE = 2'b01,
      FSPS_OP_LOCK = 2'b10
   } fsps_op_t;

   // Request from the core
   typedef struct packed
   {
      logic ctl_we;
      logic [7:0] ctl_wdata;
      logic store;
      logic load;
      logic [15:0] pointer;
      logic [15:0] data;
   } fsps_core_req_t;

   // Request to the flash macro
   typedef struct packed
   {
      logic start;
      fsps_op_t op;
      logic [PAGE_W-1:0] page;
      logic [7:0] lock_data;
   } fsps_flash_req_t;

   // Page buffer port
   typedef struct packed
   {
      logic clear;
      logic we;
      logic [WORD_W-1:0] addr;
      logic [15:0] wdata;
   } fsps_buf_req_t;

endpackage

/* File: core/fsps_sequencer.sv */
// Flash self-programming sequencer: command arming, buffer loads, erase, write, locks
module fsps_sequencer
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire fsps_pkg::fsps_core_req_t core_i,
   input wire logic eeprom_write_busy_flag_i,
   input wire logic flash_done_i,
   input wire logic [7:0] fuse_low_byte_i,
   input wire logic [7:0] fuse_high_byte_i,
   output fsps_pkg::fsps_flash_req_t flash_o,
   output logic [15:0] flash_wdata_o,
   output logic [fsps_pkg::PAGE_WORDS-1:0] page_erased_o,
   output logic [7:0] self_prog_control_reg_o,
   output logic lpm_override_o,
   output logic [7:0] lpm_data_o,
   output logic cpu_halt_o,
   output logic rww_read_block_o,
   output logic irq_o,
   output logic [7:0] lock_byte_o
);

   // ==========================================
   // State
   typedef struct packed
   {
      fsps_pkg::fsps_state_t fsm;
      logic [6:0] cmd;
      logic [2:0] age;
      logic irq_en;
      logic rww_busy;
      logic halt;
      logic [6:0] erased_page;
      logic erased_valid;
      logic [7:0] lock_byte;
      fsps_pkg::fsps_flash_req_t flash;
      logic [15:0] wdata;
      logic [4:0] wr_idx;
      logic lpm_ovr;
      logic [7:0] lpm_data;
      logic irq;
      logic [7:0] ctl;
   } fsps_seq_state_t;

   fsps_seq_state_t st_q;
   fsps_seq_state_t st_d;
   fsps_pkg::fsps_buf_req_t buf_req;
   logic [15:0] buf_rdata;
   logic [fsps_pkg::PAGE_WORDS-1:0] buf_loaded;
   logic eeprom_write_busy_flag_s1_q;
   logic eeprom_write_busy_flag_s2_q;
   logic done_s1_q;
   logic done_s2_q;
   logic done_s3_q;
   logic done_rise;

   // Page and word fields of the address pointer
   function automatic logic [6:0] page_of(input logic [15:0] ptr);
      page_of = ptr[fsps_pkg::PTR_PAGE_LSB +: fsps_pkg::PAGE_W];
   endfunction

   function automatic logic [4:0] word_of(input logic [15:0] ptr);
      word_of = ptr[fsps_pkg::PTR_WORD_LSB +: fsps_pkg::WORD_W];
   endfunction

   function automatic logic in_no_read_while_write_section(input logic [6:0] page);
      in_no_read_while_write_section = page >= fsps_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
   endfunction

   fsps_page_buffer u_buf
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(buf_req),
      .raddr_i(st_q.wr_idx),
      .rdata_o(buf_rdata),
      .loaded_o(buf_loaded)
   );

   // ==========================================
   // Pin synchronisers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         eeprom_write_busy_flag_s1_q <= 1'b0;
         eeprom_write_busy_flag_s2_q <= 1'b0;
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         done_s3_q <= 1'b0;
      end
      else
      begin
         eeprom_write_busy_flag_s1_q <= eeprom_write_busy_flag_i;
         eeprom_write_busy_flag_s2_q <= eeprom_write_busy_flag_s1_q;
         done_s1_q <= flash_done_i;
         done_s2_q <= done_s1_q;
         done_s3_q <= done_s2_q;
      end
   end

   // Completion counts once per rising edge, so a macro that holds done high
   // cannot retire a later operation early
   assign done_rise = done_s2_q && !done_s3_q;

   // ==========================================
   // Next state
   always_comb
   begin
      st_d = st_q;
      st_d.flash.start = 1'b0;
      st_d.lpm_ovr = 1'b0;
      buf_req = '0;
      buf_req.addr = word_of(core_i.pointer);
      buf_req.wdata = core_i.data;
      unique case (st_q.fsm)
         fsps_pkg::FSPS_IDLE:
         begin
            if (core_i.ctl_we && !eeprom_write_busy_flag_s2_q)
            begin
               st_d.irq_en = core_i.ctl_wdata[fsps_pkg::CTL_IRQEN_BIT];
               if (core_i.ctl_wdata[6:0] == fsps_pkg::CMD_REENABLE)
               begin
                  buf_req.clear = 1'b1;
                  st_d.rww_busy = 1'b0;
               end
               else if (core_i.ctl_wdata[fsps_pkg::CTL_ENABLE_BIT])
               begin
                  st_d.cmd = core_i.ctl_wdata[6:0];
                  st_d.age = '0;
                  st_d.fsm = fsps_pkg::FSPS_ARMED;
               end
            end
            else if (core_i.ctl_we)
            begin
               st_d.irq_en = core_i.ctl_wdata[fsps_pkg::CTL_IRQEN_BIT];
            end
         end
         fsps_pkg::FSPS_ARMED:
         begin
            st_d.age = st_q.age + 3'h1;
            if (core_i.load && st_q.cmd == fsps_pkg::CMD_READFUSE
                && st_q.age < fsps_pkg::LOAD_WINDOW && !eeprom_write_busy_flag_s2_q)
            begin
               st_d.lpm_ovr = 1'b1;
               unique case (core_i.pointer)
                  fsps_pkg::PTR_FUSE_LOW: st_d.lpm_data = fuse_low_byte_i;
                  fsps_pkg::PTR_LOCK: st_d.lpm_data = st_q.lock_byte;
                  fsps_pkg::PTR_FUSE_HIGH: st_d.lpm_data = fuse_high_byte_i;
                  default: st_d.lpm_data = 8'hff;
               endcase
               st_d.fsm = fsps_pkg::FSPS_IDLE;
            end
            else if (core_i.store && st_q.age < fsps_pkg::STORE_WINDOW && !eeprom_write_busy_flag_s2_q)
            begin
               st_d.fsm = fsps_pkg::FSPS_IDLE;
               unique case (st_q.cmd)
                  fsps_pkg::CMD_LOAD:
                     buf_req.we = 1'b1;
                  fsps_pkg::CMD_ERASE:
                  begin
                     st_d.flash.start = 1'b1;
                     st_d.flash.op = fsps_pkg::FSPS_OP_ERASE;
                     st_d.flash.page = page_of(core_i.pointer);
                     st_d.erased_page = page_of(core_i.pointer);
                     st_d.erased_valid = 1'b1;
                     st_d.fsm = fsps_pkg::FSPS_BUSY;
                  end
                  fsps_pkg::CMD_WRITE:
                  begin
                     if (st_q.erased_valid && st_q.erased_page == page_of(core_i.pointer))
                     begin
                        st_d.flash.start = 1'b1;
                        st_d.flash.op = fsps_pkg::FSPS_OP_WRITE;
                        st_d.flash.page = page_of(core_i.pointer);
                        st_d.erased_valid = 1'b0;
                        st_d.fsm = fsps_pkg::FSPS_BUSY;
                     end
                  end
                  fsps_pkg::CMD_LOCKPROG:
                  begin
                     st_d.flash.start = 1'b1;
                     st_d.flash.op = fsps_pkg::FSPS_OP_LOCK;
                     // Spare bits forced high: only boot lock bits are programmed here
                     st_d.flash.lock_data = core_i.data[7:0] | ~8'h3c;
                     st_d.lock_byte[fsps_pkg::LOCK_BOOT_MSB:fsps_pkg::LOCK_BOOT_LSB] =
                        st_q.lock_byte[5:2] & core_i.data[5:2];
                     st_d.fsm = fsps_pkg::FSPS_LOCKBUSY;
                  end
                  default:
                  begin
                  end
               endcase
               if (st_d.fsm == fsps_pkg::FSPS_BUSY)
               begin
                  st_d.rww_busy = 1'b1;
                  st_d.halt = in_no_read_while_write_section(page_of(core_i.pointer));
               end
            end
            // window timeout
            // Load window is shorter, but a late store may still follow a missed load
            else if (st_q.age >= fsps_pkg::STORE_WINDOW - 3'h1)
            begin
               st_d.fsm = fsps_pkg::FSPS_IDLE;
            end
         end
         fsps_pkg::FSPS_BUSY:
         begin
            if (done_rise)
            begin
               st_d.halt = 1'b0;
               st_d.fsm = fsps_pkg::FSPS_IDLE;
               buf_req.clear = st_q.flash.op == fsps_pkg::FSPS_OP_WRITE;
            end
         end
         fsps_pkg::FSPS_LOCKBUSY:
         begin
            if (done_rise)
            begin
               st_d.fsm = fsps_pkg::FSPS_IDLE;
            end
         end
         default:
            st_d.fsm = fsps_pkg::FSPS_IDLE;
      endcase
      // EEPROM write discards loads
      // Loads wait for the synced flag to drop, so this clear never meets a load
      if (eeprom_write_busy_flag_s2_q && |buf_loaded)
      begin
         buf_req.clear = 1'b1;
      end
      // Write index walks the buffer for the flash macro's data path
      st_d.wr_idx = st_q.wr_idx + 5'h1;
      st_d.wdata = buf_rdata;
      st_d.irq = st_d.irq_en && st_d.fsm == fsps_pkg::FSPS_IDLE;
      // Control register image is registered like every other output
      st_d.ctl = {st_d.irq_en, st_d.rww_busy, 1'b0,
         (st_d.fsm != fsps_pkg::FSPS_IDLE) ? st_d.cmd[4:1] : 4'h0,
         st_d.fsm != fsps_pkg::FSPS_IDLE};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= '0;
         st_q.fsm <= fsps_pkg::FSPS_IDLE;
         st_q.lock_byte <= fsps_pkg::LOCK_RESET;
         st_q.lpm_data <= 8'hff;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // Outputs, each straight from a flip-flop
   assign flash_o = st_q.flash;
   assign flash_wdata_o = st_q.wdata;
   assign page_erased_o = {27'h0, st_q.erased_valid, st_q.wr_idx[3:0]};
   assign self_prog_control_reg_o = st_q.ctl;
   assign lpm_override_o = st_q.lpm_ovr;
   assign lpm_data_o = st_q.lpm_data;
   assign cpu_halt_o = st_q.halt;
   assign rww_read_block_o = st_q.rww_busy;
   assign irq_o = st_q.irq;
   assign lock_byte_o = st_q.lock_byte;

endmodule

/* File: test/fsps_flash_model.sv */
// Flash macro stand-in: a one-cycle done after a short or long delay
module fsps_flash_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire fsps_pkg::fsps_flash_req_t req_i,
   input wire logic slow_i,
   output logic done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // Done is never raised without a started operation
   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      if (rst_i)
         cnt <= 0;
      else if (req_i.start)
         cnt <= slow_i ? 40 : 4;
      else if (cnt == 1)
      begin
         cnt <= 0;
         done_o <= 1'b1;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule

/* File: test/fsps_sequencer_props.sv */
// Concurrent checks on the sequencer ports
module fsps_sequencer_props
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire fsps_pkg::fsps_core_req_t core_i,
   input wire logic eeprom_write_busy_flag_i,
   input wire logic flash_done_i,
   input wire fsps_pkg::fsps_flash_req_t flash_o,
   input wire logic [7:0] self_prog_control_reg_o,
   input wire logic lpm_override_o,
   input wire logic cpu_halt_o,
   input wire logic rww_read_block_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en;
   logic lk;
   logic pg;
   assign en = self_prog_control_reg_o[0];
   assign lk = flash_o.start && flash_o.op == fsps_pkg::FSPS_OP_LOCK;
   assign pg = flash_o.start && flash_o.op != fsps_pkg::FSPS_OP_LOCK;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ==========================================
   // Multi-step antecedents
   sequence ee_blocked_cmd;
      eeprom_write_busy_flag_i [*3] ##0 (core_i.ctl_we && !en);
   endsequence
   sequence idle_arm;
      $rose(en) ##0 (!core_i.store && !core_i.load) [*6];
   endsequence

   // ==========================================
   // Assertions
   start_after_store_a:
      assert property (flash_o.start |-> $past(core_i.store)) else $error("start without store");
   page_from_ptr_a:
      assert property (pg |-> flash_o.page == $past(core_i.pointer[12:6]))
      else $error("page field wrong");
   lock_data_a:
      assert property (lk |-> flash_o.lock_data == {2'b11, $past(core_i.data[5:2]), 2'b11})
      else $error("lock data wrong");
   halt_no_read_while_write_section_a:
      assert property (pg |=> cpu_halt_o == ($past(flash_o.page) >= fsps_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE))
      else $error("halt wrong");
   rww_busy_a:
      assert property (pg |=> rww_read_block_o && self_prog_control_reg_o[6])
      else $error("section not busy");
   lock_readable_a:
      assert property (lk |=> !rww_read_block_o && !cpu_halt_o) else $error("lock op blocks");
   enable_hold_a:
      assert property (flash_o.start |-> en until flash_done_i) else $error("enable dropped");
   enable_drop_a:
      assert property ($rose(flash_done_i) |-> ##[1:5] !en) else $error("enable stuck");
   irq_level_a:
      assert property (!en && self_prog_control_reg_o[7] |-> irq_o) else $error("irq missing");
   irq_quiet_a:
      assert property (en |-> !irq_o) else $error("irq while enabled");
   arm_timeout_a:
      assert property (idle_arm |=> !en) else $error("arming not expired");
   ee_block_a:
      assert property (ee_blocked_cmd |=> !en) else $error("command taken during eeprom");
   lpm_after_load_a:
      assert property (lpm_override_o |-> $past(core_i.load)) else $error("override without load");
endmodule

bind fsps_sequencer fsps_sequencer_props u_props
(
   .clk_i(clk_i), .rst_i(rst_i), .core_i(core_i),
   .eeprom_write_busy_flag_i(eeprom_write_busy_flag_i), .flash_done_i(flash_done_i),
   .flash_o(flash_o), .self_prog_control_reg_o(self_prog_control_reg_o),
   .lpm_override_o(lpm_override_o), .cpu_halt_o(cpu_halt_o),
   .rww_read_block_o(rww_read_block_o), .irq_o(irq_o)
);

/* File: test/fsps_sequencer_tb.sv */
// Self-checking bench for the flash self-programming sequencer
module fsps_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, ee_busy, done, slow, lpm_ovr, irq;
   logic [7:0] fuse_lo, fuse_hi, lk, ctl, lpm_data;
   logic [6:0] pg;
   logic [15:0] d;
   logic [17:0] e;
   logic [17:0] exp_q[$];
   logic [7:0] lock_o;
   logic [15:0] wd;
   logic [31:0] pe;
   logic [15:0] words [16];
   fsps_pkg::fsps_core_req_t core;
   fsps_pkg::fsps_flash_req_t flash;
   int error_cnt, num_checks, i;
   integer seed = 32'h94944afd;

   fsps_sequencer dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .core_i(core), .eeprom_write_busy_flag_i(ee_busy),
      .flash_done_i(done), .fuse_low_byte_i(fuse_lo), .fuse_high_byte_i(fuse_hi),
      .flash_o(flash), .flash_wdata_o(wd), .page_erased_o(pe), .self_prog_control_reg_o(ctl),
      .lpm_override_o(lpm_ovr), .lpm_data_o(lpm_data), .cpu_halt_o(), .rww_read_block_o(),
      .irq_o(irq), .lock_byte_o(lock_o)
   );
   fsps_flash_model mdl (.clk_i(clk_i), .rst_i(rst_i), .req_i(flash), .slow_i(slow), .done_o(done));

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Bounded wait for the enable bit to clear, then let the irq register follow
   task automatic idle;
      int n;
      n = 0;
      @(negedge clk_i);
      while (ctl[0] !== 1'b0)
      begin
         @(negedge clk_i);
         n++;
         if (n > 2000)
            check("idle wait", 18'h1, 18'h0);
         if (n > 2000)
            complete_run();
      end
      repeat (2) @(posedge clk_i);
   endtask

   // Walk one full buffer rotation; the word shown trails the shown index by one
   task automatic scan(input int want);
      int n;
      n = 0;
      @(posedge clk_i);
      repeat (32)
      begin
         @(negedge clk_i);
         if (wd !== 16'hffff)
         begin
            n++;
            check("buffer word", 18'(wd), 18'(words[pe[3:0] - 4'h1]));
         end
      end
      check("buffer words", 18'(n), 18'(want));
   endtask

   task automatic cmd(input logic [7:0] w, input logic st, input logic [15:0] p,
                      input logic [15:0] dat, input int gap);
      idle();
      core.ctl_we <= 1'b1;
      core.ctl_wdata <= w;
      @(posedge clk_i);
      core.ctl_we <= 1'b0;
      repeat (gap) @(posedge clk_i);
      core.store <= st;
      core.load <= !st;
      core.pointer <= p;
      core.data <= dat;
      @(posedge clk_i);
      core.store <= 1'b0;
      core.load <= 1'b0;
   endtask

   function automatic logic [17:0] fn(fsps_pkg::fsps_op_t op, logic [6:0] p, logic [7:0] l);
      return {1'b1, op, p, l};
   endfunction

   // ==========================================
   // Result watcher: each result takes the oldest note
   always @(negedge clk_i)
   begin
      if (rst_i === 1'b0 && (flash.start === 1'b1 || lpm_ovr === 1'b1))
      begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3ffff;
         if (flash.start === 1'b1)
            check("flash request", (flash.op == fsps_pkg::FSPS_OP_LOCK) ?
               {1'b1, flash.op, 7'h0, flash.lock_data} : {1'b1, flash.op, flash.page, 8'h0}, e);
         else
            check("load result", {10'h0, lpm_data}, e);
      end
   end

   // ==========================================
   // Main sequence
   initial
   begin
      error_cnt = 0;
      num_checks = 0;
      rst_i = 1'b1;
      core = '0;
      ee_busy = 1'b0;
      slow = 1'b0;
      fuse_lo = 8'($random(seed));
      fuse_hi = 8'($random(seed));
      lk = 8'hff;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      for (i = 0; i < 4; i++)
         if (i != 2)
         begin
            exp_q.push_back({10'h0, (i == 0) ? fuse_lo : (i == 1) ? lk : fuse_hi});
            cmd(8'h09, 1'b0, 16'(i), 16'h0, 1);
         end
      // Erase then fill then write one read-while-write page; word bits are noise on erase
      pg = 7'($unsigned($random(seed)) % 96);
      exp_q.push_back(fn(fsps_pkg::FSPS_OP_ERASE, pg, 8'h0));
      cmd(8'h03, 1'b1, {3'h0, pg, 6'($random(seed))}, 16'h0, 1);
      for (i = 0; i < 4; i++)
      begin
         words[i] = 16'($random(seed)) & 16'h7fff;
         cmd(8'h01, 1'b1, {3'h0, pg, 5'(i), 1'b0}, words[i], 0);
      end
      scan(4);
      check("erased flag", 18'(pe[4]), 18'h1);
      exp_q.push_back(fn(fsps_pkg::FSPS_OP_WRITE, pg, 8'h0));
      cmd(8'h05, 1'b1, {3'h0, pg, 6'h0}, 16'h0, 1);
      cmd(8'h11, 1'b1, 16'h0, 16'h0, 1);
      scan(0);
      check("erased flag", 18'(pe[4]), 18'h0);
      // write to a page not erased
      cmd(8'h05, 1'b1, {3'h0, pg ^ 7'h01, 6'h0}, 16'h0, 1);
      slow <= 1'b1;
      exp_q.push_back(fn(fsps_pkg::FSPS_OP_ERASE, 7'h70, 8'h0));
      cmd(8'h83, 1'b1, {3'h0, 7'h70, 6'h0}, 16'h0, 1);
      idle();
      check("irq level", {17'h0, irq}, 18'h1);
      slow <= 1'b0;
      cmd(8'h11, 1'b1, 16'h0, 16'h0, 1);
      d = 16'($random(seed)) | 16'h00c3;
      lk[5:2] = lk[5:2] & d[5:2];
      exp_q.push_back(fn(fsps_pkg::FSPS_OP_LOCK, 7'h0, {2'b11, d[5:2], 2'b11}));
      cmd(8'h09, 1'b1, 16'h0001, d, 1);
      exp_q.push_back({10'h0, lk});
      cmd(8'h09, 1'b0, 16'h0001, 16'h0, 1);
      check("lock byte", 18'(lock_o), 18'(lk));
      // Store after the window and commands during an eeprom write get no result
      cmd(8'h03, 1'b1, 16'h0040, 16'h0, 6);
      words[5] = 16'($random(seed)) & 16'h7fff;
      cmd(8'h01, 1'b1, 16'h000a, words[5], 1);
      scan(1);
      @(posedge clk_i);
      ee_busy <= 1'b1;
      repeat (4) @(posedge clk_i);
      cmd(8'h03, 1'b1, 16'h0040, 16'h0, 1);
      cmd(8'h09, 1'b0, 16'h0000, 16'h0, 1);
      ee_busy <= 1'b0;
      idle();
      check("pending notes", 18'(exp_q.size()), 18'h0);
      scan(0);
      cmd(8'h01, 1'b1, 16'h000a, words[5], 1);
      scan(1);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      scan(0);
      complete_run();
   end
endmodule
